// ### design/boot_host_port.sv
`timescale 1ns/1ps
module boot_host_port
    import boot_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // software register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [WORD_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic [WORD_W-1:0]      reg_rdata,
    // host port
    boot_link_if.host              link
);

    logic [LINK_AW-1:0] tgt_addr;
    logic [WORD_W-1:0]  rd_word;
    logic               pend_wr;
    logic               pend_rd;
    logic               wait_rd;
    logic               got_rd;
    logic               busy;
    logic [WORD_W-1:0]  status;

    assign busy = pend_wr | pend_rd | wait_rd;

    // queued access goes out once the port opens
    assign link.hp_write = pend_wr && link.hp_ready;
    assign link.hp_read  = pend_rd && link.hp_ready;

    // command decode; data and control writes dropped while busy, address writes always taken
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tgt_addr      <= '0;
            link.hp_addr  <= '0;
            link.hp_wdata <= '0;
            pend_wr       <= 1'b0;
            pend_rd       <= 1'b0;
            wait_rd       <= 1'b0;
            got_rd        <= 1'b0;
            rd_word       <= '0;
        end
        else if (ce)
        begin
            if (link.hp_write)
            begin
                pend_wr <= 1'b0;
            end
            if (link.hp_read)
            begin
                pend_rd <= 1'b0;
                wait_rd <= 1'b1;
            end
            if (link.hp_rvalid && wait_rd)
            begin
                wait_rd <= 1'b0;
                got_rd  <= 1'b1;
                rd_word <= link.hp_rdata;
            end
            if (reg_write && (reg_addr == HREG_ADDR))
            begin
                tgt_addr <= reg_wdata[LINK_AW-1:0];
            end
            else if (reg_write && !busy && (reg_addr == HREG_DATA))
            begin
                link.hp_addr  <= tgt_addr;
                link.hp_wdata <= reg_wdata;
                pend_wr       <= 1'b1;
            end
            else if (reg_write && !busy && (reg_addr == HREG_CTRL) && reg_wdata[CTRL_INT_BIT])
            begin
                link.hp_addr  <= CTRL_REG_ADDR;
                link.hp_wdata <= WORD_W'(1) << FLAG_BIT;
                pend_wr       <= 1'b1;
            end
            else if (reg_write && !busy && (reg_addr == HREG_CTRL) && reg_wdata[CTRL_RD_BIT])
            begin
                link.hp_addr <= tgt_addr;
                pend_rd      <= 1'b1;
                got_rd       <= 1'b0;
            end
        end
    end

    // status word
    always_comb
    begin
        status                 = '0;
        status[STAT_BUSY_BIT]  = busy;
        status[STAT_READY_BIT] = link.hp_ready;
        status[STAT_GOT_BIT]   = got_rd;
    end

    // read data stand one cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata <= '0;
        end
        else if (ce)
        begin
            reg_rdata <= '0;
            if (reg_read)
            begin
                unique case (reg_addr)
                    HREG_ADDR:   reg_rdata <= WORD_W'(tgt_addr);
                    HREG_DATA:   reg_rdata <= rd_word;
                    HREG_STATUS: reg_rdata <= status;
                    default:     reg_rdata <= '0;
                endcase
            end
        end
    end

endmodule

// ### design/boot_link_if.sv
`timescale 1ns/1ps
interface boot_link_if;
    import boot_pkg::*;

    // host request
    logic [LINK_AW-1:0] hp_addr;
    logic [WORD_W-1:0]  hp_wdata;
    logic               hp_write;
    logic               hp_read;
    // device answer
    logic               hp_ready;
    logic               hp_rvalid;
    logic [WORD_W-1:0]  hp_rdata;

    modport device (
        input  hp_addr,
        input  hp_wdata,
        input  hp_write,
        input  hp_read,
        output hp_ready,
        output hp_rvalid,
        output hp_rdata
    );

    modport host (
        output hp_addr,
        output hp_wdata,
        output hp_write,
        output hp_read,
        input  hp_ready,
        input  hp_rvalid,
        input  hp_rdata
    );

endinterface

// ### design/boot_mode_controller.sv
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module boot_mode_controller
    import boot_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // reset pin and configuration straps
    input  wire logic              reset_n,
    input  wire logic [1:0]        cfg_boot_mode,
    input  wire logic [1:0]        cfg_rom_width,
    input  wire logic              cfg_big_endian,
    // host port
    boot_link_if.device            link,
    // rom reads in chip_enable_space_one
    output logic                   rom_read,
    output logic [ROM_AW-1:0]      rom_addr,
    input  wire logic [WORD_W-1:0] rom_data,
    // cpu side
    output logic                   cpu_stall,
    output logic                   cpu_start,
    output logic [WORD_W-1:0]      cpu_boot_addr,
    output logic                   cpu_host_int,
    input  wire logic              cpu_clear_int,
    input  wire logic [MEM_AW-1:0] cpu_addr,
    output logic [WORD_W-1:0]      cpu_rdata,
    // emulator
    input  wire logic              emu_set_int,
    // captured configuration
    output boot_mode_t             boot_mode,
    output rom_width_t             rom_width,
    output logic                   big_endian,
    output logic                   cfg_error
);

    typedef enum logic [1:0] {
        ST_RESET,
        ST_HOLD,
        ST_COPY,
        ST_RUN
    } boot_state_t;

    boot_state_t         state;
    logic                int_rst;
    logic                flag;
    logic                flag_q;
    logic                flag_set;
    logic                flag_clr;
    logic                host_wr;
    logic                host_rd;
    logic                release_cpu;
    logic                last_word;
    logic                issued_all;
    logic                rd_pending;
    logic [ROM_AW:0]     rom_step;
    logic [ROM_AW:0]     next_rom_addr;
    logic [MEM_AW-1:0]   wr_idx;
    logic [WORD_W-1:0]   pack_word;
    logic                pack_valid;
    logic [WORD_W-1:0]   mem [MEM_WORDS];

    // internal reset from pin or system reset
    assign int_rst = rst | ~reset_n;

    // straps sampled while the pin holds reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            boot_mode  <= MODE_HOST;
            rom_width  <= WIDTH_32;
            big_endian <= 1'b0;
            cfg_error  <= 1'b0;
        end
        else if (ce && !reset_n)
        begin
            boot_mode  <= (cfg_boot_mode == 2'h3) ? MODE_HOST : boot_mode_t'(cfg_boot_mode);
            rom_width  <= (cfg_rom_width == 2'h3) ? WIDTH_32 : rom_width_t'(cfg_rom_width);
            big_endian <= cfg_big_endian;
            cfg_error  <= (cfg_boot_mode == 2'h3) || (cfg_rom_width == 2'h3);
        end
    end

    // port open in hold and run
    assign link.hp_ready = (state == ST_HOLD) || (state == ST_RUN);
    assign host_wr       = link.hp_write && link.hp_ready;
    assign host_rd       = link.hp_read && link.hp_ready;

    // release on flag in host and emulator boots or end of copy
    assign last_word   = (state == ST_COPY) && pack_valid && (wr_idx == MEM_AW'(MEM_WORDS - 1));
    assign release_cpu = ((state == ST_HOLD) && flag) || last_word;

    // boot sequencing
    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
        begin
            state <= ST_RESET;
        end
        else if (ce)
        begin
            unique case (state)
                ST_RESET:
                    state <= (boot_mode == MODE_ROM) ? ST_COPY : ST_HOLD;
                ST_HOLD:
                    if (flag)
                    begin
                        state <= ST_RUN;
                    end
                ST_COPY:
                    if (last_word)
                    begin
                        state <= ST_RUN;
                    end
                ST_RUN:
                    state <= ST_RUN;
            endcase
        end
    end

    // cpu stalled until release
    assign cpu_stall = (state != ST_RUN);

    // cpu start pulse and start address
    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
        begin
            cpu_start     <= 1'b0;
            cpu_boot_addr <= BOOT_ADDR;
        end
        else if (ce)
        begin
            cpu_start     <= release_cpu;
        end
    end

    // flag: host or emulator set, cpu clears, set wins
    assign flag_set = (host_wr && link.hp_addr[CTRL_SEL_BIT] && link.hp_wdata[FLAG_BIT]) || emu_set_int;
    assign flag_clr = cpu_clear_int && (state == ST_RUN);

    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
        begin
            flag   <= FLAG_RESET;
            flag_q <= FLAG_RESET;
        end
        else if (ce)
        begin
            flag_q <= flag;
            if (flag_set)
            begin
                flag <= 1'b1;
            end
            else if (flag_clr)
            begin
                flag <= 1'b0;
            end
        end
    end

    // interrupt only on a fresh set while running
    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
        begin
            cpu_host_int <= 1'b0;
        end
        else if (ce)
        begin
            cpu_host_int <= (state == ST_RUN) && flag && !flag_q;
        end
    end

    // byte step per rom read
    always_comb
    begin
        unique case (rom_width)
            WIDTH_8:  rom_step = (ROM_AW + 1)'(1);
            WIDTH_16: rom_step = (ROM_AW + 1)'(2);
            default:  rom_step = (ROM_AW + 1)'(4);
        endcase
    end

    assign next_rom_addr = {1'b0, rom_addr} + rom_step;
    assign rom_read      = (state == ST_COPY) && !issued_all;

    // walk the image once, one read per cycle
    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
        begin
            rom_addr   <= '0;
            issued_all <= 1'b0;
            rd_pending <= 1'b0;
            wr_idx     <= '0;
        end
        else if (ce)
        begin
            rd_pending <= rom_read;
            if (rom_read)
            begin
                rom_addr   <= next_rom_addr[ROM_AW-1:0];
                issued_all <= next_rom_addr[ROM_AW];
            end
            if ((state == ST_COPY) && pack_valid)
            begin
                wr_idx <= wr_idx + 1'b1;
            end
        end
    end

    // pack narrow reads in system byte order
    boot_word_packer u_packer (
        .sys_clk    (sys_clk),
        .rst        (int_rst),
        .ce         (ce),
        .in_valid   (rd_pending),
        .in_data    (rom_data),
        .width      (rom_width),
        .big_endian (big_endian),
        .word       (pack_word),
        .word_valid (pack_valid)
    );

    // boot memory: copy writes in rom boot, host otherwise
    always_ff @(posedge sys_clk)
    begin
        if (ce)
        begin
            if ((state == ST_COPY) && pack_valid)
            begin
                mem[wr_idx] <= pack_word;
            end
            else if (host_wr && !link.hp_addr[CTRL_SEL_BIT])
            begin
                mem[link.hp_addr[MEM_AW-1:0]] <= link.hp_wdata;
            end
        end
    end

    // host read answer one cycle later
    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
        begin
            link.hp_rvalid <= 1'b0;
            link.hp_rdata  <= '0;
        end
        else if (ce)
        begin
            link.hp_rvalid <= host_rd;
            if (host_rd)
            begin
                link.hp_rdata <= link.hp_addr[CTRL_SEL_BIT] ? (WORD_W'(flag) << FLAG_BIT)
                                                            : mem[link.hp_addr[MEM_AW-1:0]];
            end
        end
    end

    // cpu fetch port
    always_ff @(posedge sys_clk)
    begin
        if (ce)
        begin
            cpu_rdata <= mem[cpu_addr];
        end
    end

endmodule

// ### design/boot_pkg.sv
package boot_pkg;

    // data path and image size
    localparam int WORD_W      = 32;
    localparam int IMAGE_BYTES = 1024;
    localparam int MEM_WORDS   = IMAGE_BYTES / 4;
    localparam int MEM_AW      = $clog2(MEM_WORDS);
    localparam int ROM_AW      = $clog2(IMAGE_BYTES);

    // cpu start address after the stall
    localparam logic [WORD_W-1:0] BOOT_ADDR = 32'h0000_0000;

    // link map: top address bit selects the control register
    localparam int                 LINK_AW       = MEM_AW + 1;
    localparam int                 CTRL_SEL_BIT  = MEM_AW;
    localparam logic [LINK_AW-1:0] CTRL_REG_ADDR = 9'h100;

    // host_port_control_register fields and reset value
    localparam int   FLAG_BIT   = 0;
    localparam logic FLAG_RESET = 1'b0;

    // host-end software registers (byte offsets)
    localparam logic [7:0] HREG_ADDR   = 8'h00;
    localparam logic [7:0] HREG_DATA   = 8'h04;
    localparam logic [7:0] HREG_CTRL   = 8'h08;
    localparam logic [7:0] HREG_STATUS = 8'h0c;

    // host-end control and status bits
    localparam int CTRL_RD_BIT    = 0;
    localparam int CTRL_INT_BIT   = 1;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_GOT_BIT   = 2;

    // boot modes and rom widths as strapped
    typedef enum logic [1:0] {
        MODE_HOST = 2'h0,
        MODE_EMU  = 2'h1,
        MODE_ROM  = 2'h2
    } boot_mode_t;

    typedef enum logic [1:0] {
        WIDTH_8  = 2'h0,
        WIDTH_16 = 2'h1,
        WIDTH_32 = 2'h2
    } rom_width_t;

endpackage

// ### design/boot_word_packer.sv
`timescale 1ns/1ps
module boot_word_packer
    import boot_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // narrow rom reads
    input  wire logic              in_valid,
    input  wire logic [WORD_W-1:0] in_data,
    input  rom_width_t             width,
    input  wire logic              big_endian,
    // packed instruction words
    output logic [WORD_W-1:0]      word,
    output logic                   word_valid
);

    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] next_acc;
    logic [1:0]        part;
    logic              last_part;

    // shift piece in; big endian puts first piece on top
    always_comb
    begin
        next_acc  = acc;
        last_part = 1'b1;
        unique case (width)
            WIDTH_8:
            begin
                next_acc  = big_endian ? {acc[23:0], in_data[7:0]} : {in_data[7:0], acc[31:8]};
                last_part = (part == 2'h3);
            end
            WIDTH_16:
            begin
                next_acc  = big_endian ? {acc[15:0], in_data[15:0]} : {in_data[15:0], acc[31:16]};
                last_part = (part == 2'h1);
            end
            default:
            begin
                next_acc  = in_data;
            end
        endcase
    end

    // hand out a word after the last piece
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            acc        <= '0;
            part       <= '0;
            word       <= '0;
            word_valid <= 1'b0;
        end
        else if (ce)
        begin
            word_valid <= 1'b0;
            if (in_valid)
            begin
                acc  <= next_acc;
                part <= last_part ? 2'h0 : part + 2'h1;
                if (last_part)
                begin
                    word       <= next_acc;
                    word_valid <= 1'b1;
                end
            end
        end
    end

endmodule

// ### test/boot_mode_controller_asserts.sv
`timescale 1ns/1ps
module boot_mode_controller_asserts
    import boot_pkg::*;
(
    // clock and resets
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               reset_n,
    // link signals
    input  wire logic [LINK_AW-1:0] hp_addr,
    input  wire logic [WORD_W-1:0]  hp_wdata,
    input  wire logic               hp_write,
    input  wire logic               hp_read,
    input  wire logic               hp_ready,
    input  wire logic               hp_rvalid,
    // controller outputs
    input  wire logic               cpu_stall,
    input  wire logic               cpu_start,
    input  wire logic               cpu_host_int,
    input  wire logic               rom_read,
    input  boot_mode_t              boot_mode
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // host write setting the flag
    sequence flag_set_s;
        hp_write && hp_ready && hp_addr == CTRL_REG_ADDR && hp_wdata[FLAG_BIT];
    endsequence
    // stall drops with one start pulse
    sequence release_s;
        !cpu_stall && cpu_start ##1 !cpu_start;
    endsequence

    AST_PIN_RESET: assert property (!reset_n |=> cpu_stall && !hp_ready && !cpu_host_int && !rom_read)
        else $error("not held in reset");
    AST_HOST_HOLD: assert property ($rose(reset_n) && boot_mode != MODE_ROM |-> ##[1:3] hp_ready && cpu_stall)
        else $error("host boot port closed");
    AST_FLAG_RELEASE: assert property ((flag_set_s ##0 cpu_stall && reset_n && boot_mode != MODE_ROM) |-> ##2 release_s)
        else $error("flag gave no release");
    AST_NO_INT_STALLED: assert property (cpu_stall |-> !cpu_host_int)
        else $error("interrupt while stalled");
    AST_INT_RUNNING: assert property (cpu_host_int |-> !$past(cpu_stall) ##1 !cpu_host_int)
        else $error("stray interrupt pulse");
    AST_START_AT_FALL: assert property ($fell(cpu_stall) |-> cpu_start)
        else $error("no start at release");
    AST_START_ONLY_FALL: assert property (cpu_start |-> $fell(cpu_stall))
        else $error("start without release");
    AST_ROM_COPY_STALL: assert property (rom_read |-> cpu_stall && !hp_ready && boot_mode == MODE_ROM)
        else $error("stray rom read");
    AST_READ_ANSWER: assert property (hp_read && hp_ready |=> hp_rvalid)
        else $error("read not answered");
    AST_ANSWER_CAUSE: assert property (hp_rvalid |-> $past(hp_read && hp_ready))
        else $error("answer without read");
    AST_STRAP_HELD: assert property (reset_n && $past(reset_n) |-> $stable(boot_mode))
        else $error("straps changed");
endmodule

// ### test/boot_mode_controller_tb_top.sv
`timescale 1ns/1ps
module boot_mode_controller_tb_top;
    import boot_pkg::*;
    // stimulus and observed signals
    logic              sys_clk = 1'b0;
    logic              rst = 1'b1;
    logic              reset_n = 1'b0;
    logic [1:0]        cfg_mode = 2'h0;
    logic [1:0]        cfg_width = 2'h0;
    logic              cfg_be = 1'b0;
    logic [7:0]        reg_addr = 8'h00;
    logic [WORD_W-1:0] reg_wdata = 32'h0;
    logic              reg_write = 1'b0;
    logic              reg_read = 1'b0;
    logic [WORD_W-1:0] reg_rdata;
    logic [WORD_W-1:0] rom_data = 32'h0;
    logic              cpu_clear_int = 1'b0;
    logic [MEM_AW-1:0] cpu_addr = 8'h00;
    logic              emu_set_int = 1'b0;
    logic              rom_read;
    logic [ROM_AW-1:0] rom_addr;
    logic              cpu_stall;
    logic              cpu_start;
    logic              cpu_host_int;
    logic [WORD_W-1:0] cpu_boot_addr;
    logic [WORD_W-1:0] cpu_rdata;
    boot_mode_t        boot_mode;
    rom_width_t        rom_width;
    logic              big_endian;
    logic              cfg_error;
    // scoreboard
    logic              rwant = 1'b0;
    logic              cwant = 1'b0;
    logic              rwant_d = 1'b0;
    logic              cwant_d = 1'b0;
    logic [WORD_W-1:0] rq[$];
    logic [WORD_W-1:0] cq[$];
    int                err_total = 0;
    int                n_compared = 0;
    int                int_cnt = 0;
    int                rr_cnt = 0;
    logic [1:0]        ex_w = 2'h0;
    logic              ex_be = 1'b0;
    logic [WORD_W-1:0] salt;
    logic [WORD_W-1:0] q;
    logic [WORD_W-1:0] w[4];

    initial forever #4 sys_clk = ~sys_clk;

    boot_link_if boot_link_if_i ();

    boot_host_port boot_host_port_i (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .link(boot_link_if_i));

    boot_mode_controller boot_mode_controller_i (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .reset_n(reset_n),
        .cfg_boot_mode(cfg_mode), .cfg_rom_width(cfg_width), .cfg_big_endian(cfg_be), .link(boot_link_if_i),
        .rom_read(rom_read), .rom_addr(rom_addr), .rom_data(rom_data), .cpu_stall(cpu_stall),
        .cpu_start(cpu_start), .cpu_boot_addr(cpu_boot_addr), .cpu_host_int(cpu_host_int),
        .cpu_clear_int(cpu_clear_int), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .emu_set_int(emu_set_int),
        .boot_mode(boot_mode), .rom_width(rom_width), .big_endian(big_endian), .cfg_error(cfg_error));

    boot_mode_controller_asserts boot_mode_controller_asserts_i (.sys_clk(sys_clk), .rst(rst),
        .reset_n(reset_n), .hp_addr(boot_link_if_i.hp_addr), .hp_wdata(boot_link_if_i.hp_wdata),
        .hp_write(boot_link_if_i.hp_write), .hp_read(boot_link_if_i.hp_read),
        .hp_ready(boot_link_if_i.hp_ready), .hp_rvalid(boot_link_if_i.hp_rvalid), .cpu_stall(cpu_stall),
        .cpu_start(cpu_start), .cpu_host_int(cpu_host_int), .rom_read(rom_read), .boot_mode(boot_mode));

    // rom piece at a byte offset
    function automatic logic [WORD_W-1:0] pc(input logic [ROM_AW-1:0] a);
        logic [WORD_W-1:0] h;
        h = ({22'h0, a} * 32'h9e3779b1) ^ salt;
        return ex_w == 2'h0 ? {24'h0, h[7:0]} : (ex_w == 2'h1 ? {16'h0, h[15:0]} : h);
    endfunction

    // packed word in system byte order
    function automatic logic [WORD_W-1:0] ew(input int i);
        logic [WORD_W-1:0] p0, p1, p2, p3;
        p0 = pc(ROM_AW'(4 * i));
        p1 = pc(ROM_AW'(4 * i + 1));
        p2 = pc(ROM_AW'(4 * i + 2));
        p3 = pc(ROM_AW'(4 * i + 3));
        if (ex_w == 2'h2)
            return p0;
        if (ex_w == 2'h1)
            return ex_be ? {p0[15:0], p2[15:0]} : {p2[15:0], p0[15:0]};
        return ex_be ? {p0[7:0], p1[7:0], p2[7:0], p3[7:0]} : {p3[7:0], p2[7:0], p1[7:0], p0[7:0]};
    endfunction

    // rom answers after a read, else inverts
    always @(posedge sys_clk)
        rom_data <= (rom_read === 1'b1) ? pc(rom_addr) : ~rom_data;

    // count interrupts and rom reads
    always @(posedge sys_clk)
    begin
        if (cpu_host_int === 1'b1)
            int_cnt++;
        if (rom_read === 1'b1)
            rr_cnt++;
    end

    // monitor pops the oldest note per result
    always @(posedge sys_clk)
    begin
        rwant_d <= rwant;
        cwant_d <= cwant;
        if (rwant_d === 1'b1)
            check(reg_rdata, rq.pop_front(), "reg_rdata");
        if (cwant_d === 1'b1)
            check(cpu_rdata, cq.pop_front(), "cpu_rdata");
    end

    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp, input string nm);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic fail(input string nm);
        err_total++;
        $display("[FAIL] %s expected done seen timeout", nm);
        test_done();
    endtask

    task automatic wr(input logic [7:0] a, input logic [WORD_W-1:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    // read; chk notes the expected value
    task automatic rd(input logic [7:0] a, input logic chk, input logic [WORD_W-1:0] e);
        if (chk)
            rq.push_back(e);
        reg_addr <= a;
        reg_read <= 1'b1;
        rwant    <= chk;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        rwant    <= 1'b0;
        #1 q = reg_rdata;
        @(posedge sys_clk);
    endtask

    task automatic poll(input int b, input logic val);
        for (int i = 0; i < 60; i++)
        begin
            rd(HREG_STATUS, 1'b0, 32'h0);
            if (q[b] === val)
                return;
        end
        fail("status poll");
    endtask

    task automatic lw(input int a, input logic [WORD_W-1:0] d);
        wr(HREG_ADDR, 32'(a));
        wr(HREG_DATA, d);
        poll(STAT_BUSY_BIT, 1'b0);
    endtask

    task automatic lr(input int a, input logic [WORD_W-1:0] e);
        wr(HREG_ADDR, 32'(a));
        wr(HREG_CTRL, 32'h1);
        poll(STAT_BUSY_BIT, 1'b0);
        poll(STAT_GOT_BIT, 1'b1);
        rd(HREG_DATA, 1'b1, e);
    endtask

    task automatic setf();
        wr(HREG_CTRL, 32'h2);
        poll(STAT_BUSY_BIT, 1'b0);
    endtask

    task automatic wait_rel(input int bound);
        for (int i = 0; i < bound; i++)
        begin
            @(posedge sys_clk);
            if (cpu_stall === 1'b0)
                return;
        end
        fail("cpu release");
    endtask

    task automatic cpu_rd(input int a, input logic [WORD_W-1:0] e);
        cq.push_back(e);
        cpu_addr <= MEM_AW'(a);
        cwant    <= 1'b1;
        @(posedge sys_clk);
        cwant <= 1'b0;
        @(posedge sys_clk);
    endtask

    // rst drops a cycle before the pin so straps are taken
    task automatic do_reset(input logic r, input logic [1:0] m, input logic [1:0] wd, input logic be);
        rst       <= r;
        reset_n   <= 1'b0;
        cfg_mode  <= m;
        cfg_width <= wd;
        cfg_be    <= be;
        ex_w      = wd;
        ex_be     = be;
        repeat (16) @(posedge sys_clk);
        check(32'(cpu_stall), 32'h1, "cpu_stall in reset");
        rst     <= 1'b0;
        @(posedge sys_clk);
        reset_n <= 1'b1;
        rr_cnt  = 0;
        @(posedge sys_clk);
        cfg_mode  <= 2'($urandom());
        cfg_width <= 2'($urandom());
        cfg_be    <= 1'($urandom());
    endtask

    // main sequence
    initial
    begin
        void'($urandom(13522));
        salt = $urandom();
        do_reset(1'b1, 2'h3, WIDTH_32, 1'b0);
        repeat (20) @(posedge sys_clk);
        check(32'(cpu_stall), 32'h1, "cpu_stall host");
        check(32'(boot_link_if_i.hp_ready), 32'h1, "hp_ready host");
        check(32'({cfg_error, boot_mode}), 32'({1'b1, MODE_HOST}), "straps host");
        for (int i = 0; i < 4; i++)
        begin
            w[i] = $urandom();
            lw(i * 85, w[i]);
        end
        for (int i = 0; i < 4; i++)
            lr(i * 85, w[i]);
        setf();
        wait_rel(40);
        check(cpu_boot_addr, BOOT_ADDR, "cpu_boot_addr");
        cpu_rd(0, w[0]);
        check(32'(int_cnt), 32'h0, "int at release");
        setf();
        repeat (8) @(posedge sys_clk);
        check(32'(int_cnt), 32'h0, "int before clear");
        cpu_clear_int <= 1'b1;
        @(posedge sys_clk);
        cpu_clear_int <= 1'b0;
        @(posedge sys_clk);
        setf();
        repeat (8) @(posedge sys_clk);
        check(32'(int_cnt), 32'h1, "int after clear");
        do_reset(1'b0, MODE_EMU, WIDTH_32, 1'b0);
        repeat (10) @(posedge sys_clk);
        check(32'(cpu_stall), 32'h1, "stall emu");
        check(32'(boot_mode), 32'(MODE_EMU), "mode emu");
        emu_set_int <= 1'b1;
        @(posedge sys_clk);
        emu_set_int <= 1'b0;
        wait_rel(40);
        check(cpu_boot_addr, BOOT_ADDR, "emu start");
        check(32'(int_cnt), 32'h1, "int emu");
        emu_set_int <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            do_reset(1'b1, MODE_ROM, 2'(k), 1'($urandom()));
            check(32'({big_endian, rom_width, boot_mode}), 32'({ex_be, 2'(k), MODE_ROM}), "straps");
            wait_rel(1600);
            check(32'(rr_cnt), 32'(IMAGE_BYTES >> k), "rom reads");
            cpu_rd(0, ew(0));
            cpu_rd(MEM_WORDS - 1, ew(MEM_WORDS - 1));
            q = 32'($urandom_range(MEM_WORDS - 1));
            cpu_rd(int'(q), ew(int'(q)));
        end
        lr(7, ew(7));
        test_done();
    end
endmodule
